/* hw/dei_pkg.sv */
// Constants, register map and carrier types of the drive enable interlock
package dei_pkg;

    // Register offsets
    localparam logic [3:0] DEI_REG_CTRL = 4'h0;
    localparam logic [3:0] DEI_REG_STATUS = 4'h4;
    localparam logic [3:0] DEI_REG_IRQ_STAT = 4'h8;
    localparam logic [3:0] DEI_REG_IRQ_MASK = 4'hC;

    // Control register fields
    localparam int DEI_CTRL_GATE_LSB = 0;
    localparam int DEI_CTRL_START_BIT = 2;
    localparam int DEI_CTRL_ERR_CLR_BIT = 3;

    // Gating modes of the effective power-fail
    localparam logic [1:0] DEI_GATE_BOTH = 2'h0;
    localparam logic [1:0] DEI_GATE_DCLINK = 2'h1;
    localparam logic [1:0] DEI_GATE_MAINS = 2'h2;
    localparam logic [1:0] DEI_GATE_NONE = 2'h3;

    // Reset values
    localparam logic [1:0] DEI_GATE_RESET = DEI_GATE_BOTH;
    localparam logic [7:0] DEI_MASK_RESET = 8'h00;

    // Interrupt event bit positions
    localparam int DEI_EV_ESTOP_MAIN = 0;
    localparam int DEI_EV_ESTOP_DRIVE = 1;
    localparam int DEI_EV_POWER_FAIL = 2;
    localparam int DEI_EV_WATCHDOG = 3;
    localparam int DEI_EV_CTRL_ERR = 4;
    localparam int DEI_EV_ENABLE_LOST = 5;
    localparam int DEI_EV_ENABLE_GAINED = 6;
    localparam int DEI_EV_COUNT = 8;

    // Sampled external inputs
    typedef struct packed {
        logic estop_input_main;
        logic estop_input_drive;
        logic dclink_power_fail;
        logic mains_phase_fail;
        logic main_cpu_watchdog_ready;
        logic ctrl_error;
    } dei_inputs_type;

    // State of the block apart from the reset synchroniser
    typedef struct packed {
        logic [1:0] gate_mode;
        logic started;
        logic err_latched;
        logic effective_power_fail;
        logic drive_ready;
        logic drive_enable;
        logic pulse_inhibit_first;
        logic [DEI_EV_COUNT-1:0] irq_stat;
        logic [DEI_EV_COUNT-1:0] irq_mask;
        logic irq;
        logic [31:0] rdata;
        dei_inputs_type prev_in;
    } dei_state_type;

endpackage

/* hw/dei_interlock.sv */
// Drive enable interlock with register port and interrupt
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module dei_interlock
    import dei_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // External enabling inputs, low active except main_cpu_watchdog_ready, which is high active
    input wire logic estop_input_main_n,
    input wire logic estop_input_drive_n,
    input wire logic dclink_power_fail_n,
    input wire logic mains_phase_fail_n,
    input wire logic main_cpu_watchdog_ready,
    // Drive controller error indication, high active
    input wire logic ctrl_error,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Interlock outputs
    output logic effective_power_fail,
    output logic drive_ready,
    output logic drive_enable,
    output logic pulse_inhibit_first_n,
    output logic irq
);

    dei_state_type s_q;
    dei_state_type s_d;
    logic rst_n;
    logic [1:0] rst_sync_q;
    dei_inputs_type in_now;

    // Released reset copy
    assign rst_n = rst_sync_q[1];

    // Gather inputs in their native polarity
    assign in_now.estop_input_main = estop_input_main_n;
    assign in_now.estop_input_drive = estop_input_drive_n;
    assign in_now.dclink_power_fail = dclink_power_fail_n;
    assign in_now.mains_phase_fail = mains_phase_fail_n;
    assign in_now.main_cpu_watchdog_ready = main_cpu_watchdog_ready;
    assign in_now.ctrl_error = ctrl_error;

    // Effective power-fail, low means fail
    function automatic logic gate_pf(input logic [1:0] mode, input logic dc, input logic ac);
        logic r;
        r = 1'b1;
        case (mode)
            DEI_GATE_BOTH: r = dc & ac;
            DEI_GATE_DCLINK: r = dc;
            DEI_GATE_MAINS: r = ac;
            DEI_GATE_NONE: r = 1'b1;
            default: r = dc & ac;
        endcase
        return r;
    endfunction

    // Register write hit
    function automatic logic wr_hit(input logic we, input logic [3:0] a, input logic [3:0] off);
        return we && (a == off);
    endfunction

    // Next state
    always_comb
    begin
        logic [DEI_EV_COUNT-1:0] ev;
        logic pf;
        logic rdy;
        logic en;
        ev = '0;
        pf = 1'b0;
        rdy = 1'b0;
        en = 1'b0;
        s_d = s_q;
        s_d.prev_in = in_now;
        // Control register
        if (wr_hit(reg_write, reg_addr, DEI_REG_CTRL))
        begin
            s_d.gate_mode = reg_wdata[DEI_CTRL_GATE_LSB +: 2];
            s_d.started = reg_wdata[DEI_CTRL_START_BIT];
        end
        // Controller error stays until cleared with the source gone
        if (in_now.ctrl_error)
            s_d.err_latched = 1'b1;
        else if (wr_hit(reg_write, reg_addr, DEI_REG_CTRL) && reg_wdata[DEI_CTRL_ERR_CLR_BIT])
            s_d.err_latched = 1'b0;
        pf = gate_pf(s_q.gate_mode, in_now.dclink_power_fail, in_now.mains_phase_fail);
        rdy = s_q.started && !s_q.err_latched && !in_now.ctrl_error;
        // Every permit must be high
        en = in_now.estop_input_main
            && in_now.estop_input_drive
            && pf
            && in_now.main_cpu_watchdog_ready
            && rdy;
        s_d.effective_power_fail = pf;
        s_d.drive_ready = rdy;
        s_d.drive_enable = en;
        s_d.pulse_inhibit_first = !in_now.main_cpu_watchdog_ready;
        // Edge events: permits falling, controller error rising, enable falling or rising
        ev[DEI_EV_ESTOP_MAIN] = s_q.prev_in.estop_input_main && !in_now.estop_input_main;
        ev[DEI_EV_ESTOP_DRIVE] = s_q.prev_in.estop_input_drive && !in_now.estop_input_drive;
        ev[DEI_EV_POWER_FAIL] = s_q.effective_power_fail && !pf;
        ev[DEI_EV_WATCHDOG] = s_q.prev_in.main_cpu_watchdog_ready
            && !in_now.main_cpu_watchdog_ready;
        ev[DEI_EV_CTRL_ERR] = !s_q.prev_in.ctrl_error && in_now.ctrl_error;
        ev[DEI_EV_ENABLE_LOST] = s_q.drive_enable && !en;
        ev[DEI_EV_ENABLE_GAINED] = !s_q.drive_enable && en;
        // Sticky status, set wins over write-one-clear
        if (wr_hit(reg_write, reg_addr, DEI_REG_IRQ_STAT))
            s_d.irq_stat = s_q.irq_stat & ~reg_wdata[DEI_EV_COUNT-1:0];
        s_d.irq_stat = s_d.irq_stat | ev;
        if (wr_hit(reg_write, reg_addr, DEI_REG_IRQ_MASK))
            s_d.irq_mask = reg_wdata[DEI_EV_COUNT-1:0];
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
        // Read data for the next cycle
        s_d.rdata = '0;
        if (reg_read)
        begin
            case (reg_addr)
                DEI_REG_CTRL: s_d.rdata = {28'h0, s_q.err_latched, s_q.started, s_q.gate_mode};
                DEI_REG_STATUS: s_d.rdata = {23'h0, s_q.drive_enable, s_q.drive_ready,
                    s_q.effective_power_fail, s_q.prev_in};
                DEI_REG_IRQ_STAT: s_d.rdata = {24'h0, s_q.irq_stat};
                DEI_REG_IRQ_MASK: s_d.rdata = {24'h0, s_q.irq_mask};
                default: s_d.rdata = '0;
            endcase
        end
    end

    // Reset synchroniser flops
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    // Remaining state on the released reset
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q.gate_mode <= DEI_GATE_RESET;
            s_q.started <= 1'b0;
            s_q.err_latched <= 1'b0;
            s_q.effective_power_fail <= 1'b0;
            s_q.drive_ready <= 1'b0;
            s_q.drive_enable <= 1'b0;
            s_q.pulse_inhibit_first <= 1'b1;
            s_q.irq_stat <= 8'h00;
            s_q.irq_mask <= DEI_MASK_RESET;
            s_q.irq <= 1'b0;
            s_q.rdata <= 32'h0000_0000;
            s_q.prev_in <= '0;
        end
        else
            s_q <= s_d;
    end

    // Outputs straight from flops, pulse_inhibit_first_n through an inverter
    assign reg_rdata = s_q.rdata;
    assign effective_power_fail = s_q.effective_power_fail;
    assign drive_ready = s_q.drive_ready;
    assign drive_enable = s_q.drive_enable;
    assign pulse_inhibit_first_n = !s_q.pulse_inhibit_first ? 1'b1 : 1'b0;
    assign irq = s_q.irq;

endmodule

/* sim/dei_far_side.sv */
// Far-side model: stop inputs, supply unit and controller
`timescale 1ns/10ps
module dei_far_side
    import dei_pkg::*;
(
    // Clock and commanded faults {main,drive,dc,ac,wd,err}
    input wire logic clock,
    input wire logic [5:0] fault,
    // Lines to the interlock
    output logic estop_input_main_n,
    output logic estop_input_drive_n,
    output logic dclink_power_fail_n,
    output logic mains_phase_fail_n,
    output logic main_cpu_watchdog_ready,
    output logic ctrl_error
);
    // Lines move just after an edge, low means fault except ctrl_error, where high means fault
    always_ff @(posedge clock)
    begin
        estop_input_main_n <= ~fault[5];
        estop_input_drive_n <= ~fault[4];
        dclink_power_fail_n <= ~fault[3];
        mains_phase_fail_n <= ~fault[2];
        main_cpu_watchdog_ready <= ~fault[1];
        ctrl_error <= fault[0];
    end
endmodule

/* sim/dei_interlock_chk.sv */
// Interlock port assertions
`timescale 1ns/10ps
module dei_interlock_chk
    import dei_pkg::*;
(
    // Clock, reset and inputs
    input wire logic clock,
    input wire logic arst_n,
    input wire logic estop_input_main_n,
    input wire logic estop_input_drive_n,
    input wire logic main_cpu_watchdog_ready,
    input wire logic ctrl_error,
    input wire logic reg_read,
    // Outputs
    input wire logic [31:0] reg_rdata,
    input wire logic effective_power_fail,
    input wire logic drive_ready,
    input wire logic drive_enable,
    input wire logic pulse_inhibit_first_n
);
    // Single domain
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence s_wd_drop; main_cpu_watchdog_ready ##1 !main_cpu_watchdog_ready; endsequence
    property p_main; !estop_input_main_n |=> !drive_enable; endproperty
    a_main: assert property (p_main) else $error("main stop");
    property p_drive; !estop_input_drive_n |=> !drive_enable; endproperty
    a_drive: assert property (p_drive) else $error("drive stop");
    property p_pf; !effective_power_fail |-> !drive_enable; endproperty
    a_pf: assert property (p_pf) else $error("power fail");
    property p_wd; s_wd_drop |=> !pulse_inhibit_first_n && !drive_enable; endproperty
    a_wd: assert property (p_wd) else $error("watchdog");
    property p_rdy; !drive_ready |-> !drive_enable; endproperty
    a_rdy: assert property (p_rdy) else $error("not ready");
    property p_err; ctrl_error |=> !drive_ready; endproperty
    a_err: assert property (p_err) else $error("ctrl error");
    property p_all; drive_enable |-> $past(estop_input_main_n) && $past(estop_input_drive_n)
        && $past(main_cpu_watchdog_ready) && effective_power_fail && drive_ready; endproperty
    a_all: assert property (p_all) else $error("grant");
    property p_idle; !reg_read |=> reg_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data");
endmodule
bind dei_interlock dei_interlock_chk i_dei_interlock_chk (.*);

/* sim/dei_interlock_tb.sv */
// Self-checking bench of the drive enable interlock
`timescale 1ns/10ps
module dei_interlock_tb
    import dei_pkg::*;
;
    // Stimulus and observed signals
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [5:0] fault = 6'h00;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata, rv;
    logic estop_input_main_n, estop_input_drive_n, dclink_power_fail_n, mains_phase_fail_n;
    logic main_cpu_watchdog_ready, ctrl_error, effective_power_fail, drive_ready;
    logic drive_enable, pulse_inhibit_first_n, irq;
    int miscompares = 0;
    int total_checks = 0;
    logic [7:0] ev [6] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h08, 8'h10};
    always #4 clock = ~clock;
    dei_far_side i_dei_far_side (.*);
    dei_interlock i_dei_interlock (.*);
    // Comparison, bus and wait helpers
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic settle;
        repeat (6) @(posedge clock);
        #1;
    endtask
    // Start, masked then unmasked interrupt, clear
    task automatic t_start;
        wr(DEI_REG_CTRL, 32'h4);
        settle;
        chk("enable", 32'h1, 32'(drive_enable));
        chk("irq", 32'h0, 32'(irq));
        rd(DEI_REG_STATUS);
        chk("status", 32'h1FE, rv);
        wr(DEI_REG_IRQ_MASK, 32'hFF);
        settle;
        chk("irq", 32'h1, 32'(irq));
        wr(DEI_REG_IRQ_STAT, 32'hFF);
        settle;
        chk("irq", 32'h0, 32'(irq));
    endtask
    // Each fault blocks, raises its event, then recovers
    task automatic t_faults;
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clock) fault <= 6'h20 >> i;
            settle;
            chk("enable", 32'h0, 32'(drive_enable));
            chk("irq", 32'h1, 32'(irq));
            if (i == 4) chk("inhibit", 32'h0, 32'(pulse_inhibit_first_n));
            rd(DEI_REG_IRQ_STAT);
            chk("events", {24'h0, ev[i] | 8'h20}, rv);
            wr(DEI_REG_IRQ_STAT, 32'hFF);
            @(posedge clock) fault <= 6'h00;
            if (i == 5) wr(DEI_REG_CTRL, 32'hC);
            settle;
            rd(DEI_REG_IRQ_STAT);
            chk("events", 32'h40, rv);
            wr(DEI_REG_IRQ_STAT, 32'hFF);
        end
    endtask
    // Every gating mode against a dc-link and a mains fault
    task automatic t_gating;
        for (int m = 0; m < 4; m++)
            for (int k = 0; k < 2; k++)
            begin
                @(posedge clock) fault <= k ? 6'h04 : 6'h08;
                wr(DEI_REG_CTRL, 32'h4 | m);
                settle;
                chk("eff pf", 32'(m[1-k]), 32'(effective_power_fail));
            end
        @(posedge clock) fault <= 6'h00;
    endtask
    // Unmapped read, then stop withdraws ready
    task automatic t_misc;
        rd(4'h2);
        chk("unmapped", 32'h0, rv);
        wr(DEI_REG_CTRL, 32'h0);
        settle;
        chk("ready", 32'h0, 32'(drive_ready));
    endtask
    // Verdict
    task automatic test_done;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (12) @(posedge clock);
        chk("inhibit", 32'h0, 32'(pulse_inhibit_first_n));
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_start;
        t_faults;
        t_gating;
        t_misc;
        test_done;
    end
endmodule
